// *** hw/evt_handler.sv ***
// Event handling unit: prioritising, masking, stacking and returning from events
`timescale 1ns/1ns
`default_nettype none
// Function
// - Every event source has a fixed priority so one winner is chosen each cycle.
// - A higher priority event may interrupt the handling of a lower one.
// - Most handlers sit four bytes apart above the vector base, a few wider.
// - Interrupt autovector offset is 14 bits, at most 16383 bytes above base.
// - Handler address is vector base OR offset, never their sum.
// - Masked events are not taken; level, exception and global masks apply.
// - NMI, unrecoverable, multiple hit and bus errors ignore all masks.
// - Interrupts set masks of their own and lower levels; critical events and NMI set all level, exception and global masks.
// - Status and PC are stacked; interrupts also stack r8-r12 and link.
// - Taking an exception other than supervisor call sets both exception and global masks.
// - After stacking, mode is set, bank follows it and PC gets handler.
// - Event return pops status and PC, plus r8-r12 and link for interrupts.
// - Supervisor call and return keep address and status on the stack.
// - Unmasked debug request sets the debug flag and jumps to its handler.
// - Debug keeps context in dedicated registers and may change mode freely.
// - Debug return leaves debug and restores the context saved at entry.
// - After reset the PC starts at 0x80000000.
// - Lookup misses and supervisor call get larger dedicated handler regions.
// - Lookup raises protection, miss and multiple hit exceptions.
// - Events of the oldest pipeline instruction are handled first.
module evt_handler #(
	parameter int N_REG = evt_pkg::REGIONS
) (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp,
	input  wire logic [evt_pkg::NUM_EXC-1:0] exc_old,
	input  wire logic [evt_pkg::NUM_EXC-1:0] exc_young,
	input  wire logic [31:0]               ret_pc_old,
	input  wire logic [31:0]               ret_pc_young,
	input  wire logic [3:0]                irq_req,
	input  wire logic [evt_pkg::AVO_W-1:0] irq_offset,
	input  wire logic                      nmi_req,
	input  wire logic                      dbg_req,
	input  wire logic [31:0]               dbg_handler,
	input  wire logic                      ins_valid,
	input  wire logic [N_REG-1:0]          ins_match,
	input  wire logic [N_REG-1:0]          ins_allow,
	input  wire logic                      dat_valid,
	input  wire logic                      dat_write,
	input  wire logic [N_REG-1:0]          dat_match,
	input  wire logic [N_REG-1:0]          dat_read_allow,
	input  wire logic [N_REG-1:0]          dat_write_allow,
	input  wire logic                      rete_req,
	input  wire logic                      rets_req,
	input  wire logic                      retd_req,
	input  wire logic [31:0]               ctx_in [evt_pkg::CTX_WORDS],
	input  wire logic [31:0]               stk_rdata,
	output logic                           stk_req_ff,
	output logic                           stk_we_ff,
	output logic [31:0]                    stk_addr_ff,
	output logic [31:0]                    stk_wdata_ff,
	output logic [31:0]                    pc_ff,
	output logic                           pc_load_ff,
	output logic [31:0]                    sr_ff,
	output logic [31:0]                    ctx_out_ff [evt_pkg::CTX_WORDS],
	output logic                           ctx_load_ff,
	output logic [3:0]                     irq_ack_ff,
	output logic                           nmi_ack_ff,
	output logic                           exc_ack_ff,
	output logic                           exc_ack_old_ff,
	output logic                           dbg_ack_ff,
	output logic                           busy_ff
);
	import evt_pkg::*;

	state_t              state_ff;
	logic [31:0]         event_vector_base_ff;
	logic [31:0]         sp_ff;
	logic [31:0]         rsr_dbg_ff;
	logic [31:0]         rar_dbg_ff;
	logic [31:0]         tgt_ff;
	logic [31:0]         nsr_ff;
	logic [4:0]          ecr_ff;
	logic [31:0]         buf_ff [STK_WORDS];
	logic [2:0]          idx_ff;
	logic [2:0]          idx_q_ff;
	logic [3:0]          cnt_ff;
	logic                cap_v_ff;
	logic [2:0]          cap_idx_ff;
	logic                dp_v_ff;
	logic                dp_write_ff;
	logic [ADDR_W-1:0]   dp_addr_ff;
	logic                imiss, imhit, iprot;
	logic                dmiss, dmhit, dprot;
	logic [NUM_EXC-1:0]  exc_o;
	logic [NUM_EXC-1:0]  exc_y;
	logic [NUM_EXC-1:0]  exc_s;
	logic                sel_old;
	logic [NUM_CAND-1:0] cand_ok;
	logic                take;
	logic [4:0]          win;
	logic                win_async;
	logic [1:0]          irq_lvl;
	logic [31:0]         ret_pc_sel;
	logic [31:0]         rd_word;
	logic                wr_en;
	logic [31:0]         sw_sr;
	logic [2:0]          cur_mode;

	// Lowest index wins, giving the fixed priority order
	function automatic logic [4:0] first_set(input logic [NUM_CAND-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NUM_CAND - 1; i >= 0; i--) begin
			if (v[i]) r = 5'(i);
		end
		return r;
	endfunction : first_set

	// Offsets: mostly 4-byte steps, wider for misses and supervisor call
	function automatic logic [AVO_W-1:0] handler_off(input logic [4:0] w, input logic [AVO_W-1:0] avo);
		if (w < 5'(NUM_CRIT)) return EXC_OFF[w];
		if (w == 5'(CAND_NMI)) return OFF_NMI;
		if (w < 5'(CAND_SYNC0)) return avo;
		return EXC_OFF[w - 5'(CAND_SYNC0 - NUM_CRIT)];
	endfunction : handler_off

	// Status word that a taken event leaves behind
	function automatic logic [31:0] event_sr(input logic [31:0] sr, input logic [4:0] w);
		logic [31:0] r;
		logic [1:0]  lvl;
		r = sr;
		lvl = 2'(5'(CAND_IRQ0) - w);
		if (w <= 5'(CAND_NMI)) begin
			// Critical events and NMI block interrupts and all exceptions but supervisor call and the critical ones
			for (int n = 0; n < 4; n++) r[SR_I0M + n] = 1'b1;
			r[SR_EM] = 1'b1;
			r[SR_GM] = 1'b1;
			r[SR_MODE_LSB +: SR_MODE_W] = (w == 5'(CAND_NMI)) ? MODE_NMI : MODE_EXC;
		end else if (w < 5'(CAND_SYNC0)) begin
			for (int n = 0; n < 4; n++) begin
				if (n <= int'(lvl)) r[SR_I0M + n] = 1'b1;
			end
			r[SR_MODE_LSB +: SR_MODE_W] = MODE_IRQ_LEVEL_ZERO + {1'b0, lvl};
		end else if (w == 5'(CAND_SCALL)) begin
			r[SR_MODE_LSB +: SR_MODE_W] = MODE_SUP;
		end else begin
			r[SR_EM] = 1'b1;
			r[SR_GM] = 1'b1;
			r[SR_MODE_LSB +: SR_MODE_W] = MODE_EXC;
		end
		return r;
	endfunction : event_sr

	// Instruction-side and data-side region lookups
	evt_prot_check #(.N(N_REG)) u_ins_chk (
		.match     (ins_match),
		.allow     (ins_allow),
		.valid     (ins_valid),
		.miss      (imiss),
		.multi_hit (imhit),
		.deny      (iprot)
	);

	evt_prot_check #(.N(N_REG)) u_dat_chk (
		.match     (dat_match),
		.allow     (dat_write ? dat_write_allow : dat_read_allow),
		.valid     (dat_valid),
		.miss      (dmiss),
		.multi_hit (dmhit),
		.deny      (dprot)
	);

	// Merge lookup faults, then pick the oldest stage
	always_comb begin
		exc_y = exc_young;
		exc_y[EXC_MHIT]  = exc_young[EXC_MHIT] | imhit;
		exc_y[EXC_IMISS] = exc_young[EXC_IMISS] | imiss;
		exc_y[EXC_IPROT] = exc_young[EXC_IPROT] | iprot;
		exc_o = exc_old;
		exc_o[EXC_MHIT]    = exc_old[EXC_MHIT] | dmhit;
		exc_o[EXC_DMISS_R] = exc_old[EXC_DMISS_R] | (dmiss & ~dat_write);
		exc_o[EXC_DMISS_W] = exc_old[EXC_DMISS_W] | (dmiss & dat_write);
		exc_o[EXC_DPROT_R] = exc_old[EXC_DPROT_R] | (dprot & ~dat_write);
		exc_o[EXC_DPROT_W] = exc_old[EXC_DPROT_W] | (dprot & dat_write);
		// A masked older event still hides the younger stage
		sel_old = |exc_o;
		exc_s = sel_old ? exc_o : exc_y;
	end

	// Mask each candidate and select the winner
	always_comb begin
		cand_ok = '0;
		for (int i = 0; i < NUM_CRIT; i++) cand_ok[i] = exc_s[i];
		cand_ok[CAND_NMI] = nmi_req;
		for (int n = 0; n < 4; n++) begin
			cand_ok[CAND_IRQ0 - n] = irq_req[n] & ~sr_ff[SR_GM] & ~sr_ff[SR_I0M + n];
		end
		for (int i = NUM_CRIT; i < NUM_EXC; i++) begin
			cand_ok[i + CAND_SYNC0 - NUM_CRIT] = exc_s[i] & (~sr_ff[SR_EM] | (i == EXC_SCALL));
		end
		take = |cand_ok;
		win = first_set(cand_ok);
		win_async = (win >= 5'(CAND_NMI)) && (win < 5'(CAND_SYNC0));
		irq_lvl = 2'(5'(CAND_IRQ0) - win);
		// Interrupts return to the oldest unfinished instruction
		ret_pc_sel = (win_async || sel_old) ? ret_pc_old : ret_pc_young;
		cur_mode = sr_ff[SR_MODE_LSB +: SR_MODE_W];
	end

	// Register read mux, sampled in the address phase
	always_comb begin
		case (haddr[ADDR_W-1:0])
			REG_SR:      rd_word = sr_ff;
			REG_EVENT_VECTOR_BASE:    rd_word = event_vector_base_ff;
			REG_ECR:     rd_word = {27'h0000000, ecr_ff};
			REG_RSR_DBG: rd_word = rsr_dbg_ff;
			REG_RAR_DBG: rd_word = rar_dbg_ff;
			REG_SYSTEM_STACK_POINTER:  rd_word = sp_ff;
			default:     rd_word = 32'h0000_0000;
		endcase
		wr_en = dp_v_ff & dp_write_ff;
		// Mode field only moves by software while in debug state
		sw_sr = sr_ff[SR_DBG] ? hwdata : ((hwdata & ~SR_MODE_MASK) | (sr_ff & SR_MODE_MASK));
	end

	// Bus slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_v_ff     <= 1'b0;
			dp_write_ff <= 1'b0;
			dp_addr_ff  <= '0;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b0;
			hresp       <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				dp_v_ff     <= hsel & htrans[1];
				dp_write_ff <= hwrite;
				dp_addr_ff  <= haddr[ADDR_W-1:0];
				if (hsel && htrans[1] && !hwrite) hrdata <= rd_word;
			end
		end
	end

	// Vector base is touched only by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_vector_base_ff <= 32'h0000_0000;
		end else if (wr_en && dp_addr_ff == REG_EVENT_VECTOR_BASE) begin
			event_vector_base_ff <= hwdata;
		end
	end

	// Event sequencer; hardware updates come last so they win over bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff       <= ST_IDLE;
			sr_ff          <= SR_RESET;
			pc_ff          <= RESET_VECTOR;
			pc_load_ff     <= 1'b0;
			sp_ff          <= 32'h0000_0000;
			rsr_dbg_ff     <= 32'h0000_0000;
			rar_dbg_ff     <= 32'h0000_0000;
			tgt_ff         <= 32'h0000_0000;
			nsr_ff         <= 32'h0000_0000;
			ecr_ff         <= 5'h00;
			idx_ff         <= 3'h0;
			idx_q_ff       <= 3'h0;
			cnt_ff         <= 4'h0;
			cap_v_ff       <= 1'b0;
			cap_idx_ff     <= 3'h0;
			stk_req_ff     <= 1'b0;
			stk_we_ff      <= 1'b0;
			stk_addr_ff    <= 32'h0000_0000;
			stk_wdata_ff   <= 32'h0000_0000;
			ctx_load_ff    <= 1'b0;
			irq_ack_ff     <= 4'h0;
			nmi_ack_ff     <= 1'b0;
			exc_ack_ff     <= 1'b0;
			exc_ack_old_ff <= 1'b0;
			dbg_ack_ff     <= 1'b0;
			busy_ff        <= 1'b0;
			for (int k = 0; k < STK_WORDS; k++) buf_ff[k] <= 32'h0000_0000;
			for (int k = 0; k < CTX_WORDS; k++) ctx_out_ff[k] <= 32'h0000_0000;
		end else begin
			pc_load_ff  <= 1'b0;
			ctx_load_ff <= 1'b0;
			irq_ack_ff  <= 4'h0;
			nmi_ack_ff  <= 1'b0;
			exc_ack_ff  <= 1'b0;
			dbg_ack_ff  <= 1'b0;
			stk_req_ff  <= 1'b0;
			stk_we_ff   <= 1'b0;
			// Stack read data returns one cycle after the request
			cap_v_ff    <= stk_req_ff & ~stk_we_ff;
			cap_idx_ff  <= idx_q_ff;
			if (cap_v_ff) buf_ff[cap_idx_ff] <= stk_rdata;
			if (wr_en && dp_addr_ff == REG_SR) sr_ff <= sw_sr;
			if (wr_en && dp_addr_ff == REG_SYSTEM_STACK_POINTER) sp_ff <= hwdata;
			if (wr_en && dp_addr_ff == REG_RSR_DBG) rsr_dbg_ff <= hwdata;
			if (wr_en && dp_addr_ff == REG_RAR_DBG) rar_dbg_ff <= hwdata;
			case (state_ff)
				ST_IDLE: begin
					busy_ff <= 1'b0;
					if (dbg_req && !sr_ff[SR_DM] && !sr_ff[SR_DBG]) begin
						// Debug context goes to dedicated registers, not the stack
						rsr_dbg_ff <= sr_ff;
						rar_dbg_ff <= ret_pc_old;
						sr_ff      <= sr_ff | DBG_ENTRY_SET;
						pc_ff      <= dbg_handler;
						pc_load_ff <= 1'b1;
						dbg_ack_ff <= 1'b1;
					end else if (retd_req && sr_ff[SR_DBG]) begin
						sr_ff      <= rsr_dbg_ff;
						pc_ff      <= rar_dbg_ff;
						pc_load_ff <= 1'b1;
					end else if (take && !busy_ff) begin
						// Requests sampled live; sources hold them until acknowledged
						buf_ff[0] <= ret_pc_sel;
						buf_ff[1] <= sr_ff;
						for (int k = 0; k < CTX_WORDS; k++) buf_ff[2 + k] <= ctx_in[CTX_WORDS - 1 - k];
						cnt_ff  <= (win >= 5'(CAND_IRQ3) && win <= 5'(CAND_IRQ0)) ? CNT_IRQ : CNT_BASIC;
						idx_ff  <= 3'h0;
						tgt_ff  <= event_vector_base_ff | {{(XLEN - AVO_W){1'b0}}, handler_off(win, irq_offset)};
						nsr_ff  <= event_sr(sr_ff, win);
						ecr_ff  <= win;
						if (win == 5'(CAND_NMI)) nmi_ack_ff <= 1'b1;
						else if (win_async) irq_ack_ff[irq_lvl] <= 1'b1;
						else exc_ack_ff <= 1'b1;
						exc_ack_old_ff <= sel_old;
						busy_ff  <= 1'b1;
						state_ff <= ST_PUSH;
					end else if ((rete_req || rets_req) && !busy_ff) begin
						// Event return frame size follows the mode being left; supervisor return always pops two words
						if (rete_req && cur_mode >= MODE_IRQ_LEVEL_ZERO && cur_mode <= MODE_IRQ_LEVEL_THREE) begin
							cnt_ff <= CNT_IRQ;
							idx_ff <= 3'(CNT_IRQ - 4'h1);
						end else begin
							cnt_ff <= CNT_BASIC;
							idx_ff <= 3'(CNT_BASIC - 4'h1);
						end
						busy_ff  <= 1'b1;
						state_ff <= ST_POP;
					end
				end
				ST_PUSH: begin
					// Full descending stack, one word per cycle
					stk_req_ff   <= 1'b1;
					stk_we_ff    <= 1'b1;
					stk_addr_ff  <= sp_ff - WORD_STEP;
					stk_wdata_ff <= buf_ff[idx_ff];
					sp_ff        <= sp_ff - WORD_STEP;
					idx_ff       <= idx_ff + 3'h1;
					if (idx_ff == 3'(cnt_ff - 4'h1)) state_ff <= ST_JUMP;
				end
				ST_JUMP: begin
					sr_ff      <= nsr_ff;
					pc_ff      <= tgt_ff;
					pc_load_ff <= 1'b1;
					state_ff   <= ST_IDLE;
				end
				ST_POP: begin
					stk_req_ff  <= 1'b1;
					stk_addr_ff <= sp_ff;
					sp_ff       <= sp_ff + WORD_STEP;
					idx_q_ff    <= idx_ff;
					idx_ff      <= idx_ff - 3'h1;
					if (idx_ff == 3'h0) state_ff <= ST_LOAD;
				end
				ST_LOAD: begin
					// Wait for the last read word to land
					if (!stk_req_ff && !cap_v_ff) begin
						sr_ff      <= buf_ff[1];
						pc_ff      <= buf_ff[0];
						pc_load_ff <= 1'b1;
						if (cnt_ff == CNT_IRQ) begin
							for (int k = 0; k < CTX_WORDS; k++) ctx_out_ff[CTX_WORDS - 1 - k] <= buf_ff[2 + k];
							ctx_load_ff <= 1'b1;
						end
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end
endmodule : evt_handler
`default_nettype wire

// *** hw/evt_prot_check.sv ***
// Region lookup check that flags miss, multiple hit and access denial
`timescale 1ns/1ns
`default_nettype none
module evt_prot_check #(
	parameter int N = 8
) (
	input  wire logic [N-1:0] match,
	input  wire logic [N-1:0] allow,
	input  wire logic         valid,
	output logic              miss,
	output logic              multi_hit,
	output logic              deny
);
	logic hit_any;
	logic hit_many;

	// Clearing the lowest set bit leaves bits only on two or more hits
	always_comb begin
		hit_any  = |match;
		hit_many = |(match & (match - N'(1)));
		miss      = valid & ~hit_any;
		multi_hit = valid & hit_many;
		deny      = valid & hit_any & ~hit_many & |(match & ~allow);
	end
endmodule : evt_prot_check
`default_nettype wire

// *** shared/evt_pkg.sv ***
// Constants, field layouts and state codes shared by the event handling unit
package evt_pkg;
	// Widths and counts
	localparam int XLEN      = 32;
	localparam int ADDR_W    = 12;
	localparam int AVO_W     = 14;
	localparam int AVO_SPAN  = 16384;
	localparam int NUM_EXC   = 21;
	localparam int NUM_CAND  = 26;
	localparam int NUM_CRIT  = 4;
	localparam int CTX_WORDS = 6;
	localparam int STK_WORDS = 8;
	localparam int REGIONS   = 8;

	// Fixed addresses and steps
	localparam logic [31:0] RESET_VECTOR = 32'h8000_0000;
	localparam logic [31:0] WORD_STEP    = 32'h0000_0004;

	// Status register fields
	localparam int SR_GM       = 16;
	localparam int SR_I0M      = 17;
	localparam int SR_EM       = 21;
	localparam int SR_MODE_LSB = 22;
	localparam int SR_MODE_W   = 3;
	localparam int SR_DM       = 26;
	localparam int SR_DBG      = 27;
	localparam logic [31:0] SR_MODE_MASK  = 32'h01C0_0000;
	localparam logic [31:0] SR_RESET      = 32'h0061_0000;
	localparam logic [31:0] DBG_ENTRY_SET = 32'h081E_0000;

	// Execution modes held in the mode field
	localparam logic [2:0] MODE_APP  = 3'h0;
	localparam logic [2:0] MODE_SUP  = 3'h1;
	localparam logic [2:0] MODE_IRQ_LEVEL_ZERO = 3'h2;
	localparam logic [2:0] MODE_IRQ_LEVEL_THREE = 3'h5;
	localparam logic [2:0] MODE_EXC  = 3'h6;
	localparam logic [2:0] MODE_NMI  = 3'h7;

	// Register byte offsets
	localparam logic [11:0] REG_SR      = 12'h000;
	localparam logic [11:0] REG_EVENT_VECTOR_BASE    = 12'h004;
	localparam logic [11:0] REG_ECR     = 12'h010;
	localparam logic [11:0] REG_RSR_DBG = 12'h030;
	localparam logic [11:0] REG_RAR_DBG = 12'h050;
	localparam logic [11:0] REG_SYSTEM_STACK_POINTER  = 12'h300;

	// Exception vector bit positions, highest priority at bit 0
	localparam int EXC_MHIT    = 1;
	localparam int EXC_IMISS   = 5;
	localparam int EXC_IPROT   = 6;
	localparam int EXC_SCALL   = 13;
	localparam int EXC_DMISS_R = 16;
	localparam int EXC_DMISS_W = 17;
	localparam int EXC_DPROT_R = 18;
	localparam int EXC_DPROT_W = 19;

	// Candidate positions in the merged priority vector
	localparam int CAND_NMI   = 4;
	localparam int CAND_IRQ3  = 5;
	localparam int CAND_IRQ0  = 8;
	localparam int CAND_SYNC0 = 9;
	localparam int CAND_SCALL = EXC_SCALL + CAND_SYNC0 - NUM_CRIT;

	// Handler offsets above the vector base
	localparam logic [13:0] OFF_NMI = 14'h0010;
	localparam logic [13:0] EXC_OFF [NUM_EXC] = '{
		14'h0000, 14'h0004, 14'h0008, 14'h000C, 14'h0014, 14'h0050, 14'h0018,
		14'h001C, 14'h0020, 14'h0024, 14'h0028, 14'h002C, 14'h0030, 14'h0100,
		14'h0034, 14'h0038, 14'h0060, 14'h0070, 14'h003C, 14'h0040, 14'h0044};

	// Stack frame sizes in words
	localparam logic [3:0] CNT_BASIC = 4'h2;
	localparam logic [3:0] CNT_IRQ   = 4'h8;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PUSH = 5'h02,
		ST_JUMP = 5'h04,
		ST_POP  = 5'h08,
		ST_LOAD = 5'h10
	} state_t;
endpackage : evt_pkg

// *** verification/evt_handler_properties.sv ***
// Temporal checks on the event unit ports
`timescale 1ns/1ns
`default_nettype none
module evt_handler_properties (
	input wire logic                          hclk,
	input wire logic                          hresetn,
	input wire logic [evt_pkg::NUM_EXC-1:0]   exc_old,
	input wire logic [evt_pkg::NUM_EXC-1:0]   exc_young,
	input wire logic                          dat_valid,
	input wire logic [3:0]                    irq_req,
	input wire logic                          nmi_req,
	input wire logic                          dbg_req,
	input wire logic [31:0]                   dbg_handler,
	input wire logic                          stk_req_ff,
	input wire logic                          stk_we_ff,
	input wire logic [31:0]                   pc_ff,
	input wire logic                          pc_load_ff,
	input wire logic [31:0]                   sr_ff,
	input wire logic [3:0]                    irq_ack_ff,
	input wire logic                          nmi_ack_ff,
	input wire logic                          exc_ack_ff,
	input wire logic                          exc_ack_old_ff,
	input wire logic                          dbg_ack_ff,
	input wire logic                          busy_ff
);
	import evt_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ack_one_hot: assert property ($onehot0({irq_ack_ff, nmi_ack_ff, exc_ack_ff, dbg_ack_ff}))
		else $error("several acks");
	a_irq_stack_eight: assert property (irq_ack_ff != 4'h0 |=> (stk_req_ff && stk_we_ff)[*8] ##1 pc_load_ff)
		else $error("bad irq frame");
	a_exc_stack_two: assert property (exc_ack_ff || nmi_ack_ff |=> (stk_req_ff && stk_we_ff)[*2] ##1 pc_load_ff)
		else $error("bad exc frame");
	a_irq_mode_masks: assert property (irq_ack_ff[3] |-> ##9 sr_ff[24:22] == MODE_IRQ_LEVEL_THREE && sr_ff[20:17] == 4'hF)
		else $error("bad level three entry");
	a_irq_needs_unmask: assert property (irq_ack_ff[0] |-> $past(!sr_ff[SR_GM] && !sr_ff[SR_I0M] && irq_req[0]))
		else $error("masked irq taken");
	a_nmi_unmasked: assert property (nmi_req && !busy_ff && !dbg_req && !sr_ff[SR_DBG] && exc_old == '0
		&& exc_young == '0 |=> nmi_ack_ff) else $error("nmi not taken");
	a_oldest_first: assert property (exc_ack_ff && $past(!dat_valid) |-> exc_ack_old_ff == $past(exc_old != '0))
		else $error("wrong stage");
	a_dbg_entry: assert property (dbg_ack_ff |-> pc_load_ff && sr_ff[SR_DBG] && pc_ff == dbg_handler && !stk_req_ff)
		else $error("debug entry wrong");
	a_no_nested_dbg: assert property (sr_ff[SR_DBG] |=> !dbg_ack_ff)
		else $error("nested debug");
	c_irq3: cover property (irq_ack_ff[3]);
	c_young_exc: cover property (exc_ack_ff && !exc_ack_old_ff);
	c_debug: cover property (dbg_ack_ff);
endmodule : evt_handler_properties
`default_nettype wire

// *** verification/evt_partner.sv ***
// Interrupt controller and stack memory model
`timescale 1ns/1ns
`default_nettype none
module evt_partner (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [3:0]  raise,
	input  wire logic [3:0]  irq_ack,
	input  wire logic        stk_req,
	input  wire logic        stk_we,
	input  wire logic [31:0] stk_addr,
	input  wire logic [31:0] stk_wdata,
	output logic      [3:0]  irq_req,
	output logic      [13:0] irq_offset,
	output logic      [31:0] stk_rdata
);
	logic [31:0] mem [logic [31:0]];
	logic [1:0]  top;
	initial stk_rdata = 32'hA5A5_5A5A;
	// Requests held until acknowledged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_req <= 4'h0;
		else
			irq_req <= (irq_req | raise) & ~irq_ack;
	end
	// Highest pending level supplies the offset
	always_comb begin
		top = 2'h0;
		for (int i = 0; i < 4; i++)
			if (irq_req[i])
				top = i[1:0];
		irq_offset = {top, 12'h104};
	end
	// Read data valid one cycle, then toggles so stale data fails
	always @(posedge hclk) begin
		if (stk_req && stk_we)
			mem[stk_addr] = stk_wdata;
		stk_rdata <= (stk_req && !stk_we) ? mem[stk_addr] : ~stk_rdata;
	end
endmodule : evt_partner
`default_nettype wire

// *** verification/tb_cpu_event_handling_unit.sv ***
// Bench for the event handling unit
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_event_handling_unit;
	import evt_pkg::*;
	localparam logic [31:0] EVB = 32'h8000_0F00;
	localparam logic [31:0] RPC = 32'h8000_0200;
	logic        hclk, hresetn, hsel, hwrite, nmi_req, dbg_req, ins_valid, dat_valid, dat_write;
	logic        rete_req, rets_req, retd_req, hreadyout, hresp, stk_req_ff, stk_we_ff, pc_load_ff;
	logic        ctx_load_ff, nmi_ack_ff, exc_ack_ff, exc_ack_old_ff, dbg_ack_ff, busy_ff;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  raise, irq_req, irq_ack_ff;
	logic [7:0]  dat_match;
	logic [13:0] irq_offset;
	logic [20:0] exc_old, exc_young;
	logic [31:0] haddr, hwdata, hrdata, stk_rdata, stk_addr_ff, stk_wdata_ff, pc_ff, sr_ff, dbg_handler, rpc, rd;
	logic [31:0] ctx_in [CTX_WORDS];
	logic [31:0] ctx_out_ff [CTX_WORDS];
	int          err_count, checks;
	// Event table: old bits, lookup, offset, mode, status
	logic [20:0] ev_old [6] = '{21'h00100, 21'h02000, 21'h0, 21'h0, 21'h0, 21'h0};
	logic [7:0]  ev_dm [6]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01};
	logic [13:0] ev_off [6] = '{14'h020, 14'h100, 14'h050, 14'h010, 14'h004, 14'h040};
	logic [2:0]  ev_md [6]  = '{MODE_EXC, MODE_SUP, MODE_EXC, MODE_NMI, MODE_EXC, MODE_EXC};
	logic [31:0] ev_sr [6]  = '{32'h0040_0000, 32'h0040_0000, 32'h0040_0000, 32'h007F_0000, 32'h007F_0000,
		32'h0040_0000};
	evt_handler dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .exc_old, .exc_young, .ret_pc_old(rpc), .ret_pc_young(32'h8000_0300),
		.irq_req, .irq_offset, .nmi_req, .dbg_req, .dbg_handler, .ins_valid, .ins_match(8'h00), .ins_allow(8'h00),
		.dat_valid, .dat_write, .dat_match, .dat_read_allow(8'h00), .dat_write_allow(8'h00), .rete_req, .rets_req,
		.retd_req, .ctx_in, .stk_rdata, .stk_req_ff, .stk_we_ff, .stk_addr_ff, .stk_wdata_ff, .pc_ff, .pc_load_ff,
		.sr_ff, .ctx_out_ff, .ctx_load_ff, .irq_ack_ff, .nmi_ack_ff, .exc_ack_ff, .exc_ack_old_ff, .dbg_ack_ff, .busy_ff);
	evt_partner partner (.hclk, .hresetn, .raise, .irq_ack(irq_ack_ff), .stk_req(stk_req_ff), .stk_we(stk_we_ff),
		.stk_addr(stk_addr_ff), .stk_wdata(stk_wdata_ff), .irq_req, .irq_offset, .stk_rdata);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// Single transfer, each phase held until hready; read data taken at the end
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
		{htrans, hwrite, haddr} <= {2'h2, w, 20'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{htrans, hwdata} <= {2'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	// Bounded wait for the jump pulse, then one more edge
	task automatic wait_pc;
		int n;
		n = 0;
		#1;
		while (pc_load_ff !== 1'b1 && n < 100) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(n < 100, 1'b1);
		@(posedge hclk);
	endtask : wait_pc
	// Pulses a return: bit 0 event, bit 1 supervisor, bit 2 debug
	task automatic ret(input logic [2:0] r);
		{retd_req, rets_req, rete_req} <= r;
		@(posedge hclk);
		{retd_req, rets_req, rete_req} <= 3'h0;
		wait_pc;
	endtask : ret
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// About 200 cycles needed; hundredfold slack
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		give_verdict();
	end
	initial begin
		{hresetn, nmi_req, dbg_req, ins_valid, dat_valid, dat_write, rete_req, rets_req, retd_req, hwrite} = '0;
		{haddr, htrans, hwdata, exc_old, exc_young, raise, dat_match} = '0;
		{hsel, hsize, dbg_handler, rpc} = {1'b1, 3'h2, 32'h9000_0000, RPC};
		for (int k = 0; k < CTX_WORDS; k++)
			ctx_in[k] = 32'hC0 + k;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(pc_ff, RESET_VECTOR);
		bus(1'b0, REG_SR, 32'h0, rd);
		chk(rd, SR_RESET);
		bus(1'b0, 12'h008, 32'h0, rd);
		chk(rd, 32'h0);
		$display("test reset done");
		bus(1'b1, REG_SYSTEM_STACK_POINTER, 32'h1000, rd);
		bus(1'b1, REG_EVENT_VECTOR_BASE, EVB, rd);
		bus(1'b1, REG_SR, 32'h0, rd);
		raise <= 4'h9;
		@(posedge hclk);
		raise <= 4'h0;
		wait_pc;
		chk(pc_ff, EVB | 32'h3104);
		chk(sr_ff[24:22], MODE_IRQ_LEVEL_THREE);
		chk(partner.mem[32'h0000_0FF8], 32'h0040_0000);
		chk(partner.mem[32'h0000_0FE0], ctx_in[0]);
		bus(1'b0, REG_SYSTEM_STACK_POINTER, 32'h0, rd);
		chk(rd, 32'h0FE0);
		repeat (10) @(posedge hclk);
		ret(3'b001);
		chk(sr_ff, 32'h0040_0000);
		chk(ctx_out_ff[5], ctx_in[5]);
		wait_pc;
		chk(pc_ff, EVB | 32'h0104);
		ret(3'b001);
		bus(1'b0, REG_SYSTEM_STACK_POINTER, 32'h0, rd);
		chk(rd, 32'h1000);
		$display("test interrupts done");
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, REG_SR, ev_sr[i], rd);
			{exc_old, exc_young} <= {ev_old[i], ((i == 0) ? 21'h1 : 21'h0)};
			{nmi_req, ins_valid, dat_write, dat_valid, dat_match} <= {i == 3, i == 2, i == 5, ev_dm[i] != 8'h0, ev_dm[i]};
			wait_pc;
			{exc_old, exc_young, nmi_req, ins_valid, dat_valid, dat_match} <= '0;
			chk(pc_ff, EVB | ev_off[i]);
			chk(sr_ff[24:22], ev_md[i]);
			chk(sr_ff[SR_EM] & sr_ff[SR_GM], ev_md[i] != MODE_SUP);
			ret((i == 1) ? 3'b010 : 3'b001);
			chk(sr_ff, ev_sr[i]);
			if (i != 2 && i != 3)
				chk(pc_ff, RPC);
		end
		$display("test exceptions done");
		dbg_req <= 1'b1;
		wait_pc;
		dbg_req <= 1'b0;
		chk(pc_ff, 32'h9000_0000);
		chk(sr_ff[SR_DBG], 1'b1);
		bus(1'b0, REG_RAR_DBG, 32'h0, rd);
		chk(rd, RPC);
		bus(1'b0, REG_RSR_DBG, 32'h0, rd);
		chk(rd, 32'h0040_0000);
		bus(1'b1, REG_SR, 32'h0880_0000, rd);
		bus(1'b0, REG_SR, 32'h0, rd);
		chk(rd[24:22], MODE_IRQ_LEVEL_ZERO);
		ret(3'b100);
		chk(pc_ff, RPC);
		chk(sr_ff, 32'h0040_0000);
		$display("test debug done");
		give_verdict();
	end
endmodule : tb_cpu_event_handling_unit
bind evt_handler evt_handler_properties props (.hclk, .hresetn, .exc_old, .exc_young, .dat_valid, .irq_req, .nmi_req,
	.dbg_req, .dbg_handler, .stk_req_ff, .stk_we_ff, .pc_ff, .pc_load_ff, .sr_ff, .irq_ack_ff, .nmi_ack_ff,
	.exc_ack_ff, .exc_ack_old_ff, .dbg_ack_ff, .busy_ff);
`default_nettype wire
